// ### design/rrs_pkg.sv
// Package: constants and carrier types for the return/rotate/subtract execution block.
package rrs_pkg;
   // ----------------------------------------------------------------
   // Opcode patterns (14-bit instruction word)
   // ----------------------------------------------------------------
   localparam logic [13:0] OPC_RETURN      = 14'h0008;
   localparam logic [5:0]  OPC_RRC_HI      = 6'h0c;
   localparam logic [4:0]  OPC_LIT_SUB_HI  = 5'h1e;
   localparam int          RRC_HI_POS      = 8;
   localparam int          LSUB_HI_POS     = 9;
   localparam int          DEST_BIT_POS    = 7;
   localparam int          FILE_ADDR_W     = 7;
   localparam int          PC_W            = 13;
   localparam int          RETURN_CYCLES   = 2;
   localparam logic [7:0]  ACC_RESET       = 8'h00;
   localparam logic [PC_W-1:0] PC_RESET    = 13'h0000;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic carry;
      logic half_carry_flag;
      logic zero;
   } rrs_flags_type;

   typedef struct packed {
      logic                   we;
      logic [FILE_ADDR_W-1:0] addr;
      logic [7:0]             data;
   } rrs_file_wr_type;

   typedef enum logic [1:0] {
      ALU_NONE,
      ALU_ROT,
      ALU_SUB
   } rrs_alu_op_type;
endpackage : rrs_pkg

// ### design/rrs_alu.sv
// Module: combinational rotate-through-carry and literal-minus-accumulator unit.
`timescale 1ns/1ps
`default_nettype none
module rrs_alu
   import rrs_pkg::*;
(
   input  wire logic           [7:0] operand_a,
   input  wire logic           [7:0] acc,
   input  wire rrs_flags_type        flags_in,
   input  wire rrs_alu_op_type       op,
   output logic                [7:0] result,
   output rrs_flags_type             flags_out
);
   logic [8:0] diff;
   logic [4:0] low_diff;

   always_comb begin
      diff      = {1'b0, operand_a} - {1'b0, acc};
      low_diff  = {1'b0, operand_a[3:0]} - {1'b0, acc[3:0]};
      result    = operand_a;
      flags_out = flags_in;
      unique case (op)
         ALU_ROT: begin
            result          = {flags_in.carry, operand_a[7:1]};
            flags_out.carry = operand_a[0];
         end
         ALU_SUB: begin
            result                    = diff[7:0];
            flags_out.carry           = ~diff[8];
            flags_out.half_carry_flag = ~low_diff[4];
            flags_out.zero            = (diff[7:0] == 8'h00);
         end
         default: begin
            result = operand_a;
         end
      endcase
   end
endmodule : rrs_alu
`default_nettype wire

// ### design/rrs_exec.sv
// Module: execution of subroutine return, rotate right through carry and literal subtract.
`timescale 1ns/1ps
`default_nettype none
module rrs_exec
   import rrs_pkg::*;
(
   input  wire logic                   clk_sys,
   input  wire logic                   rst,
   input  wire logic                   instr_valid,
   input  wire logic [13:0]            instr,
   input  wire logic [7:0]             file_rd_data,
   input  wire logic [PC_W-1:0]        stack_top_entry,
   input  wire logic [PC_W-1:0]        pc_in,
   output logic      [FILE_ADDR_W-1:0] file_rd_addr,
   output rrs_file_wr_type             file_wr,
   output logic                        stack_pop,
   output logic                        busy,
   output logic      [PC_W-1:0]        program_counter,
   output logic      [7:0]             acc,
   output rrs_flags_type               flags
);
   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {ST_RUN, ST_RET_FLUSH} rrs_state_type;

   rrs_state_type   state_q;
   rrs_state_type   state_d;
   logic            is_ret;
   logic            is_rot;
   logic            is_sub;
   logic            dest_file;
   logic            take;
   rrs_alu_op_type  op;
   logic [7:0]      alu_res;
   rrs_flags_type   alu_flags;
   logic [7:0]      operand;

   // Instructions arriving while the return flushes are dropped; fetch must hold off on busy.
   assign take      = instr_valid && (state_q == ST_RUN);
   assign is_ret    = take && (instr == OPC_RETURN);
   assign is_rot    = take && (instr[13:RRC_HI_POS] == OPC_RRC_HI);
   assign is_sub    = take && (instr[13:LSUB_HI_POS] == OPC_LIT_SUB_HI);
   assign dest_file = instr[DEST_BIT_POS];
   assign file_rd_addr = instr[FILE_ADDR_W-1:0];
   assign busy      = (state_q == ST_RET_FLUSH);
   assign stack_pop = is_ret;

   always_comb begin
      op      = ALU_NONE;
      operand = file_rd_data;
      if (is_rot) begin
         op = ALU_ROT;
      end else if (is_sub) begin
         op      = ALU_SUB;
         operand = instr[7:0];
      end
   end

   rrs_alu u_alu (
      .operand_a (operand),
      .acc       (acc),
      .flags_in  (flags),
      .op        (op),
      .result    (alu_res),
      .flags_out (alu_flags)
   );

   // ----------------------------------------------------------------
   // Return sequencing
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_RUN:       if (is_ret) state_d = ST_RET_FLUSH;
         ST_RET_FLUSH: state_d = ST_RUN;
         default:      state_d = ST_RUN;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) state_q <= ST_RUN;
      else     state_q <= state_d;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst)         program_counter <= PC_RESET;
      else if (is_ret) program_counter <= stack_top_entry;
      else if (take)   program_counter <= pc_in;
   end

   // ----------------------------------------------------------------
   // Accumulator, flags and file write
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         acc <= ACC_RESET;
      end else if (is_sub || (is_rot && !dest_file)) begin
         acc <= alu_res;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst)                  flags <= '0;
      else if (is_rot || is_sub) flags <= alu_flags;
   end

   // The file write lands one edge late, so a read of the same register in the
   // next cycle still sees the old value; the file side must forward it.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         file_wr <= '0;
      end else begin
         file_wr.we   <= is_rot && dest_file;
         file_wr.addr <= instr[FILE_ADDR_W-1:0];
         file_wr.data <= alu_res;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_ret_issue;
      is_ret;
   endsequence

   sequence s_ret_flush;
      busy ##1 !busy;
   endsequence

   AST_RET_LOADS_PC: assert property (@(posedge clk_sys) disable iff (rst)
      is_ret |=> program_counter == $past(stack_top_entry))
      else $error("return did not load stack top into program counter");

   AST_RET_KEEPS_FLAGS: assert property (@(posedge clk_sys) disable iff (rst)
      is_ret |=> $stable(flags))
      else $error("return changed flags");

   AST_RET_TWO_CYCLES: assert property (@(posedge clk_sys) disable iff (rst)
      s_ret_issue |=> s_ret_flush)
      else $error("return did not take two cycles");

   AST_ROT_VALUE: assert property (@(posedge clk_sys) disable iff (rst)
      (is_rot && !dest_file) |=>
         acc == {$past(flags.carry), $past(file_rd_data[7:1])}
         && flags.carry == $past(file_rd_data[0]))
      else $error("rotate result or carry wrong");

   AST_ROT_TO_ACC: assert property (@(posedge clk_sys) disable iff (rst)
      (is_rot && !dest_file) |=> !file_wr.we)
      else $error("rotate to accumulator wrote the file");

   AST_ROT_TO_FILE: assert property (@(posedge clk_sys) disable iff (rst)
      (is_rot && dest_file) |=> file_wr.we && $stable(acc)
         && file_wr.addr == $past(instr[FILE_ADDR_W-1:0]))
      else $error("rotate to file did not write back");

   AST_SUB_RESULT: assert property (@(posedge clk_sys) disable iff (rst)
      is_sub |=> acc == 8'($past(instr[7:0]) - $past(acc)))
      else $error("literal subtract result wrong");

   AST_SUB_CARRY: assert property (@(posedge clk_sys) disable iff (rst)
      is_sub |=> flags.carry == ($past(instr[7:0]) >= $past(acc)))
      else $error("literal subtract carry wrong");

   AST_SUB_ZERO: assert property (@(posedge clk_sys) disable iff (rst)
      is_sub |=> flags.zero == (acc == 8'h00) && !busy)
      else $error("literal subtract zero flag wrong");

   // ----------------------------------------------------------------
   // Checks on file write-back data, half carry and what must stay put
   // ----------------------------------------------------------------
   sequence s_rot_file_issue;
      is_rot && dest_file;
   endsequence

   sequence s_flush_cycle;
      busy;
   endsequence

   AST_ROT_FILE_DATA: assert property (@(posedge clk_sys) disable iff (rst)
      s_rot_file_issue |=>
         file_wr.data == {$past(flags.carry), $past(file_rd_data[7:1])}
         && flags.carry == $past(file_rd_data[0]))
      else $error("rotate to file wrote wrong data or carry");

   AST_ROT_ONLY_CARRY: assert property (@(posedge clk_sys) disable iff (rst)
      is_rot |=> flags.half_carry_flag == $past(flags.half_carry_flag)
         && flags.zero == $past(flags.zero))
      else $error("rotate changed a flag other than carry");

   AST_WE_FROM_ROT: assert property (@(posedge clk_sys) disable iff (rst)
      file_wr.we |-> $past(is_rot && dest_file))
      else $error("file write without a rotate to file");

   AST_SUB_HALF_CARRY: assert property (@(posedge clk_sys) disable iff (rst)
      is_sub |=> flags.half_carry_flag == ($past(instr[3:0]) >= $past(acc[3:0])))
      else $error("literal subtract half carry wrong");

   AST_SUB_NO_WRITE: assert property (@(posedge clk_sys) disable iff (rst)
      is_sub |=> !file_wr.we)
      else $error("literal subtract wrote the file");

   AST_RET_KEEPS_ACC: assert property (@(posedge clk_sys) disable iff (rst)
      is_ret |=> $stable(acc) && !file_wr.we)
      else $error("return changed accumulator or wrote the file");

   AST_FLUSH_IDLE: assert property (@(posedge clk_sys) disable iff (rst)
      s_flush_cycle |=> $stable(acc) && $stable(flags) && !file_wr.we
         && $stable(program_counter))
      else $error("instruction executed in the return flush cycle");
endmodule : rrs_exec
`default_nettype wire

// ### dv/rrs_tb.sv
// Self-checking testbench for the return, rotate and literal subtract block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import rrs_pkg::*;
   logic                   clk_sys = 1'b0;
   logic                   rst = 1'b1;
   logic                   instr_valid = 1'b0;
   logic [13:0]            instr = 14'h0000;
   logic [7:0]             file_rd_data = 8'h00;
   logic [PC_W-1:0]        stack_top_entry = 13'h0000;
   logic [PC_W-1:0]        pc_in = 13'h0000;
   logic [FILE_ADDR_W-1:0] file_rd_addr;
   rrs_file_wr_type        file_wr;
   logic                   stack_pop;
   logic                   busy;
   logic [PC_W-1:0]        program_counter;
   logic [7:0]             acc;
   rrs_flags_type          flags;
   int                     n_fail = 0;
   int                     checks = 0;
   int                     cycles = 0;
   logic [7:0]             w_m = 8'h00;
   rrs_flags_type          f_m = 3'h0;
   always #50 clk_sys = ~clk_sys;
   rrs_exec DUT (.clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid), .instr(instr),
      .file_rd_data(file_rd_data), .stack_top_entry(stack_top_entry), .pc_in(pc_in),
      .file_rd_addr(file_rd_addr), .file_wr(file_wr), .stack_pop(stack_pop), .busy(busy),
      .program_counter(program_counter), .acc(acc), .flags(flags));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic issue(input logic [13:0] op, input logic [7:0] fd, input logic [12:0] pcn);
      instr = op;
      file_rd_data = fd;
      pc_in = pcn;
      instr_valid = 1'b1;
      @(posedge clk_sys);
      #1;
   endtask : issue
   task automatic results;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : results
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   // Back-to-back subtracts over borrow, zero and half-carry boundaries, both encodings.
   task automatic sub_seq;
      logic [7:0] ks [10] = '{8'h01, 8'h02, 8'h01, 8'h00, 8'h10, 8'h0f, 8'hff, 8'h00, 8'hff, 8'h20};
      for (int i = 0; i < 10; i++) begin
         issue({5'h1e, i[0], ks[i]}, 8'h5a, 13'h0100 + 13'(i));
         f_m = {ks[i] >= w_m, ks[i][3:0] >= w_m[3:0], ks[i] == w_m};
         w_m = ks[i] - w_m;
         chk("sub acc", 16'(acc), 16'(w_m));
         chk("sub carry", 16'(flags.carry), 16'(f_m.carry));
         chk("sub hc zero", 16'(flags[1:0]), 16'(f_m[1:0]));
         chk("sub pc", 16'(program_counter), 16'h0100 + 16'(i));
      end
      instr_valid = 1'b0;
   endtask : sub_seq
   // Rotate into the accumulator, then into the top file address.
   task automatic rot_seq;
      logic [7:0] r;
      r = {f_m.carry, 7'h73};
      issue(14'h0c05, 8'he6, 13'h0200);
      chk("rot d0 acc", 16'(acc), 16'(r));
      chk("rot d0 carry", 16'(flags.carry), 16'h0000);
      chk("rot d0 we", 16'(file_wr.we), 16'h0000);
      instr = 14'h0cff;
      file_rd_data = 8'h81;
      #1;
      chk("rot addr", 16'(file_rd_addr), 16'h007f);
      issue(14'h0cff, 8'h81, 13'h0201);
      chk("rot d1 wr", 16'(file_wr), {1'b1, 7'h7f, 8'h40});
      chk("rot d1 carry", 16'(flags.carry), 16'h0001);
      chk("rot d1 acc", 16'(acc), 16'(r));
      instr_valid = 1'b0;
      @(posedge clk_sys);
      #1;
      chk("rot we pulse", 16'(file_wr.we), 16'h0000);
   endtask : rot_seq
   // Return with an instruction held valid through the dead cycle.
   task automatic ret_seq;
      stack_top_entry = 13'h1abc;
      instr = OPC_RETURN;
      instr_valid = 1'b1;
      #1;
      chk("pop", 16'(stack_pop), 16'h0001);
      issue(OPC_RETURN, 8'h00, 13'h0300);
      chk("ret pc", 16'(program_counter), 16'h1abc);
      chk("ret flags", 16'(flags), {13'h0, 3'b100});
      chk("ret busy", 16'(busy), 16'h0001);
      chk("pop in busy", 16'(stack_pop), 16'h0000);
      issue(14'h3c77, 8'h00, 13'h0301);
      chk("busy drop", 16'(busy), 16'h0000);
      chk("ignored acc", 16'(acc), 16'h0073);
      chk("ignored pc", 16'(program_counter), 16'h1abc);
      issue(14'h3c77, 8'h00, 13'h0302);
      chk("after ret", 16'(acc), 16'h0004);
      chk("after ret pc", 16'(program_counter), 16'h0302);
      instr_valid = 1'b0;
   endtask : ret_seq
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 2000) begin
         n_fail++;
         results();
      end
   end
   initial begin
      repeat (3) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      chk("reset acc", 16'(acc), 16'(ACC_RESET));
      chk("reset flags", 16'(flags), 16'h0000);
      sub_seq();
      rot_seq();
      ret_seq();
      results();
   end
endmodule : testbench
`default_nettype wire
